// >>> hdl/ccac_core.sv
// capacity accounting core: counters, learned capacity, pin decode, registers
`timescale 1ns/1ps

// Overview of operation
// RULE1: writing 00h to 1eh then 05h resets
// RULE2: temperature register upper digit gives 10C band
// RULE3: temperature band selects charge and self-discharge factors
// RULE4: load compensation adds to discharge counting
// RULE5: self-discharge uses load compensation and temperature
// RULE6: charge raises capacity; discharge lowers, counts discharge
// RULE7: offset register corrects capacity counting each second
// RULE8: learn only after clean full-to-empty discharge
// RULE9: charge never lifts capacity above full reference
// RULE10: initialization loads learned capacity with full count
// RULE11: learned capacity drops at most one quarter
// RULE12: display reference: learned (relative) or full count
// RULE13: full count sets initial capacity and scale
// RULE14: pins one and two select count and scale
// RULE15: pin three selects self-discharge base rate
// RULE16: pin four selects overload threshold, mode, timer; the hold timer is fixed at DISP_HOLD_S
// RULE17: charge-complete input sets capacity to learned
// RULE18: discharge counter saturates, clears at full capacity
// RULE19: supply recovery check reinitializes on corrupted state
// RULE20: program pins sampled once per initialization, held
module ccac_core
	import ccac_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DFLT
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// raw pins and front-end events
	input wire ccac_pins_s pins_i,
	// register port from the serial link logic
	input wire ccac_reg_req_s reg_req_i,
	output ccac_reg_rsp_s reg_rsp_o,
	// capacity state
	output logic [15:0] nac_o,
	output logic [15:0] dcr_o,
	output logic [15:0] lmd_o,
	output logic [15:0] full_ref_o,
	output logic [7:0] temp_band_o,
	// display configuration
	output logic abs_mode_o,
	output logic [7:0] overload_mv_o,
	output logic display_on_o,
	output logic ready_o
);

	////////////////////////////////////////////////////////////////////////////
	// decode functions

	function automatic logic [27:0] pfc_sel(input logic [3:0] p);
		logic [27:0] v;
		v = {16'h7000, 12'h280};
		case (p)
			{LVL_HIGH, LVL_HIGH}: v = {16'h6a00, 12'h140};
			{LVL_FLOAT, LVL_HIGH}: v = {16'h5e00, 12'h140};
			{LVL_LOW, LVL_HIGH}: v = {16'ha200, 12'h280};
			{LVL_HIGH, LVL_FLOAT}: v = {16'h8900, 12'h280};
			{LVL_FLOAT, LVL_FLOAT}: v = {16'h7000, 12'h280};
			{LVL_LOW, LVL_FLOAT}: v = {16'haf00, 12'h500};
			{LVL_HIGH, LVL_LOW}: v = {16'h7800, 12'h500};
			{LVL_FLOAT, LVL_LOW}: v = {16'h9600, 12'ha00};
			{LVL_LOW, LVL_LOW}: v = {16'h3200, 12'ha00};
			default: v = {16'h7000, 12'h280};
		endcase
		return v;
	endfunction

	function automatic logic [3:0] band_of(input logic [3:0] t);
		return (t > TEMP_BAND_MAX) ? TEMP_BAND_MAX : t;
	endfunction

	// doubling per 10C step, base rate at 20-30C
	function automatic logic [3:0] sd_shift(input logic [1:0] p3, input logic [3:0] b);
		logic [3:0] base;
		logic [3:0] c;
		base = (p3 == LVL_HIGH) ? 4'h6 : ((p3 == LVL_FLOAT) ? 4'h7 : 4'h9);
		c = (b < 4'h4) ? 4'h4 : ((b > 4'hb) ? 4'hb : b);
		return 4'(base + 4'h6 - c);
	endfunction

	// trickle efficiency in hundredths
	function automatic logic [6:0] chg_eff(input logic [1:0] p5, input logic [3:0] b);
		logic [1:0] rng;
		rng = (b <= 4'h6) ? 2'h0 : ((b <= 4'h8) ? 2'h1 : 2'h2);
		case (p5)
			LVL_HIGH: chg_eff = 7'(7'h50 - 7'(rng) * 7'h05);
			LVL_LOW: chg_eff = 7'(7'h55 - 7'(rng) * 7'h05);
			default: chg_eff = CHG_EFF_DEN;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	ccac_core_s r;
	ccac_core_s n;
	logic chg_ev;
	logic dis_ev;
	logic emp_ev;
	logic sup_rise;
	logic btn_fall;
	logic sec_tick;
	logic learn_ev;
	logic [3:0] band;
	logic [27:0] sel;
	logic [19:0] cthr;
	logic [15:0] floor_lmd;
	logic [7:0] ofs_mag;

	assign chg_ev = r.ps.charge & ~r.pd.charge;
	assign dis_ev = r.ps.discharge & ~r.pd.discharge;
	assign emp_ev = r.ps.empty & ~r.pd.empty;
	assign sup_rise = r.ps.supply_ok & ~r.pd.supply_ok;
	assign btn_fall = ~r.ps.button & r.pd.button;
	assign sec_tick = (r.sec_cnt == 24'(SEC_CYCLES - 1));
	assign band = band_of(r.ps.temp);
	assign sel = pfc_sel(r.ps.program_pin[3:0]);
	assign cthr = 20'(r.scale) * 20'(CHG_EFF_DEN);
	assign floor_lmd = 16'(r.learned_capacity - (r.learned_capacity >> 2));
	assign ofs_mag = 8'(~r.ofs + 8'h01);

	always_comb begin
		n = r;
		learn_ev = 1'b0;
		n.pm = pins_i;
		n.ps = r.pm;
		n.pd = r.ps;
		n.sec_cnt = sec_tick ? 24'h00_0000 : 24'(r.sec_cnt + 24'h00_0001);
		n.rsp.valid = 1'b0;
		// no display while initializing
		n.disp_on = 1'b0;
		case (r.st)
			CCAC_ST_INIT: begin
				n.init_cnt = 2'(r.init_cnt + 2'h1);
				if (r.init_cnt == INIT_WAIT) begin
					n.lvl = r.ps.program_pin; // RULE20
					n.initial_full_count = sel[27:12]; // RULE14
					n.scale = sel[11:0]; // RULE13
					n.learned_capacity = sel[27:12]; // RULE10
					n.available_capacity_counter = 16'h0000;
					n.discharge_counter = 16'h0000;
					n.cacc = 20'h0_0000;
					n.dacc = 16'h0000;
					n.sacc = 32'h0000_0000;
					n.full_seen = 1'b0;
					n.partial = 1'b0;
					n.qualified = 1'b0;
					n.learned = 1'b0;
					n.rst_arm = 1'b0;
					n.st = CCAC_ST_RUN;
				end
			end
			CCAC_ST_RUN: begin
				// register writes
				if (reg_req_i.wr) begin
					case (reg_req_i.addr)
						ADDR_LMD: n.learned_capacity = {reg_req_i.wdata, 8'h00};
						ADDR_OFS: n.ofs = reg_req_i.wdata;
						ADDR_LOAD_COMPENSATION: n.load_compensation = reg_req_i.wdata;
						ADDR_PROGRAMMED_FULL_COUNT_CFG: n.programmed_full_count_cfg = reg_req_i.wdata;
						default: n.programmed_full_count_cfg = r.programmed_full_count_cfg;
					endcase
					n.rst_arm = (reg_req_i.addr == ADDR_PROGRAMMED_FULL_COUNT_CFG) && (reg_req_i.wdata == RST_CMD_VAL); // RULE1
				end
				if (reg_req_i.rd) begin
					n.rsp.valid = 1'b1;
					case (reg_req_i.addr)
						ADDR_NAC: n.rsp.data = r.available_capacity_counter[15:8];
						ADDR_DCR: n.rsp.data = r.discharge_counter[15:8];
						ADDR_LMD: n.rsp.data = r.learned_capacity[15:8];
						ADDR_TEMP: n.rsp.data = {band, 4'h0}; // RULE2
						ADDR_OFS: n.rsp.data = r.ofs;
						ADDR_LOAD_COMPENSATION: n.rsp.data = r.load_compensation;
						ADDR_PROGRAMMED_FULL_COUNT_CFG: n.rsp.data = r.programmed_full_count_cfg;
						default: n.rsp.data = 8'h00;
					endcase
				end
				// accumulate compensated counts
				n.cacc = 20'(r.cacc + (chg_ev ? 20'(chg_eff(r.lvl[9:8], band)) : 20'h0_0000)); // RULE3
				n.dacc = 16'(r.dacc + 16'(dis_ev));
				n.sacc = r.sacc;
				if (sec_tick) begin
					n.dacc = 16'(n.dacc + 16'(r.load_compensation)); // RULE4
					n.sacc = 32'(r.sacc + 32'(r.available_capacity_counter >> sd_shift(r.lvl[5:4], band)) + 32'(r.load_compensation)); // RULE5 RULE15
					if (r.ofs[7]) begin
						n.dacc = 16'(n.dacc + 16'(ofs_mag)); // RULE7
					end else begin
						n.cacc = 20'(n.cacc + 20'(r.ofs)); // RULE7
					end
				end
				// one capacity step per cycle; leftovers wait in the accumulators
				if (r.ps.done) begin
					n.available_capacity_counter = n.learned_capacity; // RULE17
				end else if (r.cacc >= cthr) begin
					n.cacc = 20'(n.cacc - cthr);
					if (r.qualified) begin
						learn_ev = 1'b1; // RULE8
						n.learned_capacity = (r.discharge_counter < floor_lmd) ? floor_lmd : r.discharge_counter; // RULE11
						n.available_capacity_counter = 16'h0000;
						n.qualified = 1'b0;
						n.learned = 1'b1;
					end else if (r.available_capacity_counter < n.learned_capacity) begin
						n.available_capacity_counter = 16'(r.available_capacity_counter + 16'h0001); // RULE6 RULE9
						n.partial = r.full_seen | r.partial;
					end
				end else if (r.dacc >= 16'(r.scale)) begin
					n.dacc = 16'(n.dacc - 16'(r.scale));
					n.available_capacity_counter = (r.available_capacity_counter != 16'h0000) ? 16'(r.available_capacity_counter - 16'h0001) : r.available_capacity_counter; // RULE6
					n.discharge_counter = (r.discharge_counter == DCR_MAX) ? r.discharge_counter : 16'(r.discharge_counter + 16'h0001); // RULE18
				end else if (r.sacc >= DAY_S) begin
					n.sacc = 32'(n.sacc - DAY_S);
					if (r.available_capacity_counter != 16'h0000) begin
						n.available_capacity_counter = 16'(r.available_capacity_counter - 16'h0001); // RULE6
						n.discharge_counter = (r.discharge_counter == DCR_MAX) ? r.discharge_counter : 16'(r.discharge_counter + 16'h0001); // RULE18
					end
				end
				// a lowered reference must not leave capacity above it
				if (n.available_capacity_counter > n.learned_capacity) begin
					n.available_capacity_counter = n.learned_capacity; // RULE9
				end
				if (n.available_capacity_counter == n.learned_capacity) begin
					n.discharge_counter = 16'h0000; // RULE18
					n.full_seen = 1'b1;
					n.partial = 1'b0;
				end else if (emp_ev) begin
					n.qualified = r.full_seen & ~r.partial; // RULE8
					n.full_seen = 1'b0;
				end
				// display push-button hold timer
				if (r.ps.button) begin
					n.disp_cnt = 3'h0;
				end else if (btn_fall) begin
					n.disp_cnt = DISP_HOLD_S; // RULE16
				end else if (sec_tick && r.disp_cnt != 3'h0) begin
					n.disp_cnt = 3'(r.disp_cnt - 3'h1);
				end
				n.disp_on = r.ps.button | (n.disp_cnt != 3'h0);
				// reinitialize on command or on corrupted backup state
				if (reg_req_i.wr && reg_req_i.addr == ADDR_LMD &&
					reg_req_i.wdata == RST_CMD_VAL && r.rst_arm) begin
					n.st = CCAC_ST_INIT; // RULE1
					n.init_cnt = 2'h0;
				end
				if (sup_rise && r.cks != (r.available_capacity_counter ^ r.learned_capacity ^ r.discharge_counter)) begin
					n.st = CCAC_ST_INIT; // RULE19
					n.init_cnt = 2'h0;
				end
			end
			default: begin
				n.st = CCAC_ST_INIT;
				n.init_cnt = 2'h0;
			end
		endcase
		n.cks = n.available_capacity_counter ^ n.learned_capacity ^ n.discharge_counter; // RULE19
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			r <= '0;
			r.st <= CCAC_ST_INIT;
			r.ofs <= OFS_RST;
			r.load_compensation <= LOAD_COMPENSATION_RST;
			r.programmed_full_count_cfg <= PROGRAMMED_FULL_COUNT_CFG_RST;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rsp_o = r.rsp;
	assign nac_o = r.available_capacity_counter;
	assign dcr_o = r.discharge_counter;
	assign lmd_o = r.learned_capacity;
	assign abs_mode_o = (r.lvl[7:6] == LVL_LOW); // RULE16
	assign full_ref_o = abs_mode_o ? r.initial_full_count : r.learned_capacity; // RULE12
	assign overload_mv_o = abs_mode_o ? OVLD_ABS_MV : OVLD_REL_MV; // RULE16
	assign temp_band_o = {band_of(r.ps.temp), 4'h0};
	assign display_on_o = r.disp_on;
	assign ready_o = (r.st == CCAC_ST_RUN);

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	chk_dcr_saturate: assert property ( // RULE18
		(r.st == CCAC_ST_RUN && n.st == CCAC_ST_RUN && r.discharge_counter == DCR_MAX && n.available_capacity_counter != n.learned_capacity)
		|=> (r.discharge_counter == DCR_MAX)) else $error("discharge counter wrapped");
	chk_dcr_full_clear: assert property ( // RULE18
		(r.available_capacity_counter == r.learned_capacity) |-> (r.discharge_counter == 16'h0000)) else $error("discharge counter not cleared");
	chk_nac_ceiling: assert property ( // RULE9
		(r.st == CCAC_ST_RUN) |-> (r.available_capacity_counter <= r.learned_capacity)) else $error("capacity above reference");
	chk_done_load: assert property ( // RULE17
		(r.st == CCAC_ST_RUN && n.st == CCAC_ST_RUN && r.ps.done) |=> (r.available_capacity_counter == r.learned_capacity))
		else $error("charge complete did not load capacity");
	// idle cycles and reads may sit between the two command writes
	chk_reset_cmd: assert property ( // RULE1
		(r.st == CCAC_ST_RUN && r.rst_arm && reg_req_i.wr && reg_req_i.addr == ADDR_LMD &&
		reg_req_i.wdata == RST_CMD_VAL) |=> (r.st == CCAC_ST_INIT)) else $error("reset command ignored");
	chk_reset_arm: assert property ( // RULE1
		(r.st == CCAC_ST_RUN && n.st == CCAC_ST_RUN && reg_req_i.wr) |=> (r.rst_arm ==
		($past(reg_req_i.addr) == ADDR_PROGRAMMED_FULL_COUNT_CFG && $past(reg_req_i.wdata) == RST_CMD_VAL)))
		else $error("reset command arming wrong");
	chk_init_load: assert property ( // RULE10
		(r.st == CCAC_ST_INIT && n.st == CCAC_ST_RUN) |=> (r.learned_capacity == r.initial_full_count && r.available_capacity_counter == 16'h0000 &&
		r.initial_full_count == $past(sel[27:12]))) else $error("initialization load wrong");
	chk_learn_floor: assert property ( // RULE11
		learn_ev |=> (r.learned_capacity >= $past(floor_lmd) && r.learned)) else $error("learned drop too large");
	chk_temp_read: assert property ( // RULE2
		(r.st == CCAC_ST_RUN && reg_req_i.rd && reg_req_i.addr == ADDR_TEMP)
		|=> (r.rsp.valid && r.rsp.data == {$past(band), 4'h0})) else $error("temperature read wrong");
	chk_pins_held: assert property ( // RULE20
		(r.st == CCAC_ST_RUN && n.st == CCAC_ST_RUN) |=> $stable(r.lvl)) else $error("pins resampled");
	chk_mode_decode: assert property ( // RULE16
		(r.st == CCAC_ST_RUN) |-> (overload_mv_o == (r.lvl[7:6] == LVL_LOW ? OVLD_ABS_MV : OVLD_REL_MV)))
		else $error("overload decode wrong");

	cov_learn: cover property (learn_ev);
	cov_done: cover property (r.st == CCAC_ST_RUN && r.ps.done ##1 r.available_capacity_counter == r.learned_capacity);
	cov_reset_cmd: cover property (r.st == CCAC_ST_RUN ##1 r.st == CCAC_ST_INIT);
	cov_dcr_sat: cover property (r.discharge_counter == DCR_MAX);

endmodule

// >>> common/ccac_pkg.sv
// shared constants, types and state layout of the capacity accounting core
package ccac_pkg;

	// time base
	localparam int CLK_HZ = 10_000_000;
	localparam int SEC_S = 1;
	localparam int SEC_CYCLES_DFLT = CLK_HZ * SEC_S;
	localparam logic [2:0] DISP_HOLD_S = 3'h4;
	localparam logic [31:0] DAY_S = 32'h0001_5180;

	// register offsets
	localparam logic [7:0] ADDR_NAC = 8'h03;
	localparam logic [7:0] ADDR_DCR = 8'h04;
	localparam logic [7:0] ADDR_LMD = 8'h05;
	localparam logic [7:0] ADDR_TEMP = 8'h06;
	localparam logic [7:0] ADDR_OFS = 8'h0b;
	localparam logic [7:0] ADDR_LOAD_COMPENSATION = 8'h0e;
	localparam logic [7:0] ADDR_PROGRAMMED_FULL_COUNT_CFG = 8'h1e;

	// reset values and command value
	localparam logic [7:0] OFS_RST = 8'h00;
	localparam logic [7:0] LOAD_COMPENSATION_RST = 8'h00;
	localparam logic [7:0] PROGRAMMED_FULL_COUNT_CFG_RST = 8'h00;
	localparam logic [7:0] RST_CMD_VAL = 8'h00;

	// counter limits
	localparam logic [15:0] DCR_MAX = 16'hffff;
	localparam logic [3:0] TEMP_BAND_MAX = 4'hc;
	localparam logic [6:0] CHG_EFF_DEN = 7'h64;
	localparam logic [1:0] INIT_WAIT = 2'h3;

	// three-level pin codes
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_FLOAT = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;

	// overload threshold magnitudes in mV
	localparam logic [7:0] OVLD_REL_MV = 8'h4b;
	localparam logic [7:0] OVLD_ABS_MV = 8'h19;

	typedef enum logic [1:0] {
		CCAC_ST_INIT = 2'b00,
		CCAC_ST_RUN = 2'b01
	} ccac_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ccac_reg_req_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ccac_reg_rsp_s;

	typedef struct packed {
		logic charge;
		logic discharge;
		logic done;
		logic empty;
		logic supply_ok;
		logic button;
		logic [3:0] temp;
		logic [11:0] program_pin;
	} ccac_pins_s;

	typedef struct packed {
		ccac_state_e st;
		logic [1:0] init_cnt;
		ccac_pins_s pm;
		ccac_pins_s ps;
		ccac_pins_s pd;
		logic [11:0] lvl;
		logic [15:0] initial_full_count;
		logic [11:0] scale;
		logic [15:0] available_capacity_counter;
		logic [15:0] learned_capacity;
		logic [15:0] discharge_counter;
		logic [15:0] cks;
		logic [7:0] ofs;
		logic [7:0] load_compensation;
		logic [7:0] programmed_full_count_cfg;
		logic [19:0] cacc;
		logic [15:0] dacc;
		logic [31:0] sacc;
		logic [23:0] sec_cnt;
		logic [2:0] disp_cnt;
		logic disp_on;
		logic full_seen;
		logic partial;
		logic qualified;
		logic learned;
		logic rst_arm;
		ccac_reg_rsp_s rsp;
	} ccac_core_s;

endpackage

// >>> sim/ccac_host.sv
// host model: one-cycle register requests on the core's register port
`timescale 1ns/1ps
module ccac_host
	import ccac_pkg::*;
(
	// clock
	input wire logic clock_i,
	// register requests
	output ccac_reg_req_s req_o
);
	initial req_o = '0;
	// idle bus after a request shows inverted address and data, never the last value
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1 req_o = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule

// >>> sim/tb.sv
// self-checking bench of the capacity accounting core
`timescale 1ns/1ps
module tb;
	import ccac_pkg::*;
	localparam int SEC = 20;
	localparam logic [15:0] PFC_TAB [9] = '{16'h3200, 16'h9600, 16'h7800, 16'haf00, 16'h7000,
		16'h8900, 16'ha200, 16'h5e00, 16'h6a00};
	logic clock_i;
	logic sys_rst_i;
	ccac_pins_s pins;
	ccac_reg_req_s req;
	ccac_reg_rsp_s rsp;
	logic [15:0] available_capacity_counter, discharge_counter, learned_capacity, fref;
	logic [7:0] tband, ovl;
	logic absm, disp, rdy;
	logic [7:0] exp_q [$];
	int err_total = 0;
	int n_compared = 0;
	int seed = 45;

	ccac_core #(.SEC_CYCLES(SEC)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pins_i(pins),
		.reg_req_i(req), .reg_rsp_o(rsp), .nac_o(available_capacity_counter), .dcr_o(discharge_counter), .lmd_o(learned_capacity),
		.full_ref_o(fref), .temp_band_o(tband), .abs_mode_o(absm), .overload_mv_o(ovl),
		.display_on_o(disp), .ready_o(rdy));
	ccac_host host (.clock_i(clock_i), .req_o(req));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic note(input string m);
		err_total++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic cmp_port(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) note("port value");
	endtask
	task automatic cmp_rsp(input logic [7:0] got);
		n_compared++;
		if (exp_q.size() == 0) note("read answer without request");
		else if (got !== exp_q.pop_front()) note("read data");
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, 8'h00);
	endtask
	task automatic wait_rdy(input logic v);
		int i;
		for (i = 0; i < 40 && rdy !== v; i++) cyc(1);
		if (rdy !== v) begin
			note("ready wait ran out");
			tally_and_finish();
		end
	endtask
	// pulses two cycles high, two low: inside the pin spacing limit
	task automatic pulse(input int kind, input int n);
		repeat (n) begin
			if (kind == 0) pins.charge = 1'b1;
			else if (kind == 1) pins.discharge = 1'b1;
			else pins.empty = 1'b1;
			cyc(2);
			pins.charge = 1'b0;
			pins.discharge = 1'b0;
			pins.empty = 1'b0;
			cyc(2);
		end
		cyc(10);
	endtask
	task automatic reinit(input logic [11:0] p);
		pins.program_pin = p;
		cyc(3);
		host.xfer(1'b1, ADDR_PROGRAMMED_FULL_COUNT_CFG, RST_CMD_VAL);
		host.xfer(1'b1, ADDR_LMD, RST_CMD_VAL);
		wait_rdy(1'b0);
		wait_rdy(1'b1);
	endtask

	always @(posedge clock_i) if (rsp.valid === 1'b1) cmp_rsp(rsp.data);

	initial begin
		#9_000_000;
		note("run too long");
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [11:0] p;
		logic [1:0] m;
		logic [3:0] t;
		logic [7:0] d;
		logic [15:0] base;
		pins = '0;
		sys_rst_i = 1'b1;
		cyc(6);
		sys_rst_i = 1'b0;
		wait_rdy(1'b1);
		cmp_port(learned_capacity, PFC_TAB[0]);
		cmp_port(available_capacity_counter, 16'h0000);
		// a write between the two command writes must disarm it
		host.xfer(1'b1, ADDR_PROGRAMMED_FULL_COUNT_CFG, RST_CMD_VAL);
		host.xfer(1'b1, ADDR_OFS, 8'h00);
		host.xfer(1'b1, ADDR_LMD, RST_CMD_VAL);
		cyc(8);
		cmp_port({15'h0000, rdy}, 16'h0001);
		cmp_port(learned_capacity, 16'h0000);
		for (i = 0; i < 9; i++) begin
			m = 2'((i + 1) % 3);
			p = {2'h0, 2'h1, m, 2'({$random(seed)} % 3), 2'(i % 3), 2'(i / 3)};
			reinit(p);
			cmp_port(learned_capacity, PFC_TAB[i]);
			cmp_port(fref, PFC_TAB[i]);
			cmp_port({15'h0000, absm}, {15'h0000, m == LVL_LOW});
			cmp_port({8'h00, ovl}, {8'h00, m == LVL_LOW ? OVLD_ABS_MV : OVLD_REL_MV});
		end
		for (i = 0; i < 17; i++) begin
			t = (i < 16) ? 4'(i) : 4'($random(seed));
			pins.temp = t;
			cyc(5);
			d = {(t > TEMP_BAND_MAX) ? TEMP_BAND_MAX : t, 4'h0};
			rd(ADDR_TEMP, d);
			cmp_port({8'h00, tband}, {8'h00, d});
		end
		pins.temp = 4'h6;
		// pins H,H: scale 320, relative mode, unity charge factor
		reinit(12'h19a);
		pulse(0, 320);
		cmp_port(available_capacity_counter, 16'h0001);
		pulse(1, 320);
		cmp_port(available_capacity_counter, 16'h0000);
		cmp_port(discharge_counter, 16'h0001);
		pulse(1, 320);
		cmp_port(available_capacity_counter, 16'h0000);
		cmp_port(discharge_counter, 16'h0002);
		pins.done = 1'b1;
		cyc(6);
		cmp_port(available_capacity_counter, 16'h6a00);
		cmp_port(discharge_counter, 16'h0000);
		pins.done = 1'b0;
		cyc(4);
		// short discharge to empty: learned drop limited to a quarter
		pulse(1, 640);
		pulse(2, 1);
		pulse(0, 320);
		cmp_port(learned_capacity, 16'h4f80);
		cmp_port(available_capacity_counter, 16'h0000);
		cmp_port(fref, 16'h4f80);
		pins.done = 1'b1;
		cyc(6);
		pins.done = 1'b0;
		cyc(4);
		pulse(0, 320);
		cmp_port(available_capacity_counter, 16'h4f80);
		pins.program_pin = 12'h000;
		cyc(8);
		cmp_port({8'h00, ovl}, {8'h00, OVLD_REL_MV});
		pins.button = 1'b1;
		cyc(5);
		pins.button = 1'b0;
		cyc(10);
		cmp_port({15'h0000, disp}, 16'h0001);
		cyc(150);
		cmp_port({15'h0000, disp}, 16'h0000);
		d = 8'($random(seed));
		host.xfer(1'b1, ADDR_OFS, d);
		rd(ADDR_OFS, d);
		d = 8'($random(seed));
		host.xfer(1'b1, ADDR_LOAD_COMPENSATION, d);
		rd(ADDR_LOAD_COMPENSATION, d);
		rd(8'h20, 8'h00);
		rd(ADDR_LMD, 8'h4f);
		cyc(4);
		cmp_port(16'(exp_q.size()), 16'h0000);
		// load plus negative offset compensation: 80 + 80 discharge counts a second
		host.xfer(1'b1, ADDR_OFS, 8'hb0);
		host.xfer(1'b1, ADDR_LOAD_COMPENSATION, 8'h50);
		pins.button = 1'b1;
		cyc(5);
		pins.button = 1'b0;
		cyc(4);
		// display going off marks a second tick, so the window below is tick aligned
		for (i = 0; i < 200 && disp !== 1'b0; i++) cyc(1);
		cmp_port({15'h0000, disp}, 16'h0000);
		cyc(1);
		base = discharge_counter;
		// twenty ticks of 160 counts: exactly ten scale-320 steps
		cyc(400);
		cmp_port(discharge_counter, 16'(base + 16'h000a));
		tally_and_finish();
	end
endmodule
